// [cgsbo_pkg.sv]
// package: constants, state and carrier types of the can global status block
package cgsbo_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_STATUS   = 8'h00;
   localparam logic [7:0] OFF_EWL      = 8'h04;
   localparam logic [7:0] OFF_CTRL     = 8'h08;
   localparam int         CTRL_SRM_BIT = 0;

   // ---------------------------------------------------------------
   // reset values and counter limits
   // ---------------------------------------------------------------
   localparam logic [7:0] EWL_RESET    = 8'h60;
   localparam logic [7:0] TEC_BUSOFF   = 8'h7F;
   localparam logic [7:0] MAX_ERR      = 8'hFF;
   localparam logic [7:0] REC_PASSIVE  = 8'h7F;
   localparam logic [8:0] TX_ERR_STEP  = 9'h008;
   localparam logic [8:0] RX_ERR_STEP8 = 9'h008;
   localparam logic [8:0] RX_ERR_STEP1 = 9'h001;
   localparam logic [3:0] BUS_FREE_LAST = 4'hA;
   localparam logic [7:0] RECOVER_LAST = 8'h7F;
   localparam int         NUM_TXBUF    = 3;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_ACTIVE   = 2'b00,
      ST_BUSOFF   = 2'b01,
      ST_RECOVER  = 2'b11,
      ST_WAIT_ONE = 2'b10
   } cgsbo_mode_t;

   typedef struct packed {
      logic tx_busy;
      logic rx_busy;
      logic bit_tick;
      logic bit_recessive;
      logic tx_ok;
      logic tx_err;
      logic rx_ok;
      logic rx_err;
      logic rx_err8;
   } cgsbo_evt_t;

   typedef struct packed {
      logic [NUM_TXBUF-1:0] req;
      logic [NUM_TXBUF-1:0] done;
      logic [NUM_TXBUF-1:0] abort;
   } cgsbo_txq_t;

   typedef struct packed {
      logic msg_valid;
      logic release_rx_buffer_cmd;
      logic clr_overrun;
   } cgsbo_rx_t;

   typedef struct packed {
      cgsbo_mode_t          mode;
      logic [7:0]           tec;
      logic [7:0]           rec;
      logic [7:0]           ewl;
      logic                 srm;
      logic                 bus_off;
      logic                 err_flag;
      logic                 tx_all_done_flag;
      logic [NUM_TXBUF-1:0] tx_pend;
      logic [1:0]           rx_cnt;
      logic                 overrun;
      logic                 idle_wait;
      logic [3:0]           rb_cnt;
      logic [7:0]           rcv_cnt;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic                 warn_evt;
   } cgsbo_state_t;

endpackage

// [cgsbo_top.sv]
// module: can global status, error confinement and bus-off recovery
`timescale 1ns/1ps
// Functional notes
// - error flag bit 6 set when either counter reaches warning limit; warn event
// - transmit status bit 5 is 1 while sending or in soft reset
// - receive status bit 4 is 1 while receiving or in soft reset
// - bit 3 is set when the last pending transmission succeeds and no pending buffer is aborted in that cycle
// - bit 2 is 1 when no transmit buffer holds an unsent message
// - bit 1 is set when a message is lost to a full buffer
// - bit 0 is 1 while a message is buffered; cleared by release when empty
// - tx counter beyond 255 sets bus-off and soft reset mode; warn event
// - bus-off entry loads tx counter with 127 and clears rx counter
// - bus-off holds until software clears soft reset mode or writes tx counter 0..254
// - recovery waits 128 bus-free events, decrementing tx counter on each but the last, which clears it
// - recovery end clears bus-off, error flag, both counters; warn event
// - tx counter reads show the live recovery countdown
// - tx and rx errors and successes move counters per confinement rules
// - warning limit resets to 96
// - both status bits 0 means idle, both 1 means waiting for idle
// - idle needs 11 recessive bits; after bus-off 128 such sequences
// - any transmit request outside soft reset clears bit 3 until all are sent
// - message arriving with no free buffer is dropped, overrun on valid
// - dropped message that fails gives no overrun
// - counters sit in bits 31:24 and 23:16; writable only in soft reset
// - tx counter write 0..254 during bus-off clears it; one bus-free wait
// - bit 7 is bus-off flag
module cgsbo_top
   import cgsbo_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire cgsbo_evt_t  evt,
   input  wire cgsbo_txq_t  txq,
   input  wire cgsbo_rx_t   rxi,
   output logic             soft_reset_mode,
   output logic             bus_off,
   output logic             err_warn_event
);

   // ---------------------------------------------------------------
   // state and decode
   // ---------------------------------------------------------------
   cgsbo_state_t s_q;
   cgsbo_state_t s_d;
   logic         bus_free;
   logic         wr_acc;
   logic         addr_hit;
   logic [31:0]  status_w;
   logic [8:0]   tec_up;
   logic         ts_w;
   logic         rs_w;
   logic [1:0]   rx_cnt_w;

   // eleven recessive bits in a row make one bus-free event
   assign bus_free = evt.bit_tick & evt.bit_recessive
                   & (s_q.rb_cnt == BUS_FREE_LAST);
   assign wr_acc   = psel & penable & pwrite & s_q.pready;
   assign addr_hit = (paddr == OFF_STATUS) | (paddr == OFF_EWL)
                   | (paddr == OFF_CTRL);
   assign tec_up   = {1'b0, s_q.tec} + TX_ERR_STEP;

   // both status bits high while soft reset or waiting for idle
   assign ts_w = s_q.srm | s_q.idle_wait | (s_q.mode != ST_ACTIVE)
               | evt.tx_busy;
   assign rs_w = s_q.srm | s_q.idle_wait | (s_q.mode != ST_ACTIVE)
               | evt.rx_busy;

   assign status_w = {s_q.tec, s_q.rec, 8'h00,
                      s_q.bus_off,
                      s_q.err_flag,
                      ts_w, rs_w,
                      s_q.tx_all_done_flag,
                      (s_q.tx_pend == '0),
                      s_q.overrun,
                      (s_q.rx_cnt != 2'h0)};

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      rx_cnt_w = s_q.rx_cnt;

      // apb: setup cycle prepares answer, access cycle completes
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      if (psel && !penable && !s_q.pready) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = ~addr_hit;
         case (paddr)
            OFF_STATUS: s_d.prdata = status_w;
            OFF_EWL:    s_d.prdata = {24'h000000, s_q.ewl};
            OFF_CTRL:   s_d.prdata = {31'h00000000, s_q.srm};
            default:    s_d.prdata = 32'h00000000;
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            OFF_EWL:  s_d.ewl = pwdata[7:0];
            OFF_CTRL: s_d.srm = pwdata[CTRL_SRM_BIT];
            OFF_STATUS: begin
               // low status byte is read only
               if (s_q.srm) begin
                  s_d.tec = pwdata[31:24];
                  if (!s_q.bus_off) begin
                     s_d.rec = pwdata[23:16];
                  end
                  if (s_q.bus_off && pwdata[31:24] != MAX_ERR) begin
                     s_d.bus_off = 1'b0;
                     s_d.mode    = ST_WAIT_ONE;
                  end
               end
            end
            default: s_d.ewl = s_q.ewl;
         endcase
      end

      // recessive bit run counter
      if (evt.bit_tick) begin
         if (!evt.bit_recessive || bus_free) begin
            s_d.rb_cnt = 4'h0;
         end else begin
            s_d.rb_cnt = s_q.rb_cnt + 4'h1;
         end
      end

      // transmit queue and receive buffer
      if (s_q.srm) begin
         s_d.tx_pend = '0;
         s_d.rx_cnt  = 2'h0;
         s_d.overrun = 1'b0;
      end else begin
         s_d.tx_pend = (s_q.tx_pend & ~txq.done & ~txq.abort) | txq.req;
         if (|txq.req) begin
            s_d.tx_all_done_flag = 1'b0;
         end else if (s_d.tx_pend == '0 && |(txq.done & s_q.tx_pend)
                      && !(|(txq.abort & s_q.tx_pend))) begin
            s_d.tx_all_done_flag = 1'b1;
         end
         if (rxi.release_rx_buffer_cmd && rx_cnt_w != 2'h0) begin
            rx_cnt_w = rx_cnt_w - 2'h1;
         end
         // only a completed message strobes msg_valid
         if (rxi.msg_valid) begin
            if (s_q.rx_cnt == 2'h2) begin
               s_d.overrun = 1'b1;
            end else begin
               rx_cnt_w = rx_cnt_w + 2'h1;
            end
         end else if (rxi.clr_overrun) begin
            s_d.overrun = 1'b0;
         end
         s_d.rx_cnt = rx_cnt_w;
      end

      // error confinement and bus-off sequence
      case (s_q.mode)
         ST_ACTIVE: begin
            if (bus_free) begin
               s_d.idle_wait = 1'b0;
            end
            if (!s_q.srm) begin
               if (evt.tx_err && tec_up > {1'b0, MAX_ERR}) begin
                  s_d.mode      = ST_BUSOFF;
                  s_d.bus_off   = 1'b1;
                  s_d.srm       = 1'b1;
                  s_d.tec       = TEC_BUSOFF;
                  s_d.rec       = 8'h00;
                  s_d.idle_wait = 1'b1;
               end else begin
                  if (evt.tx_err) begin
                     s_d.tec = tec_up[7:0];
                  end else if (evt.tx_ok && s_q.tec != 8'h00) begin
                     s_d.tec = s_q.tec - 8'h01;
                  end
                  if (evt.rx_err8) begin
                     s_d.rec = ({1'b0, s_q.rec} + RX_ERR_STEP8 > 9'h0FF)
                             ? MAX_ERR : s_q.rec + RX_ERR_STEP8[7:0];
                  end else if (evt.rx_err) begin
                     s_d.rec = ({1'b0, s_q.rec} + RX_ERR_STEP1 > 9'h0FF)
                             ? MAX_ERR : s_q.rec + RX_ERR_STEP1[7:0];
                  end else if (evt.rx_ok) begin
                     if (s_q.rec > REC_PASSIVE) begin
                        s_d.rec = REC_PASSIVE;
                     end else if (s_q.rec != 8'h00) begin
                        s_d.rec = s_q.rec - 8'h01;
                     end
                  end
               end
            end
         end
         ST_BUSOFF: begin
            // held until software leaves soft reset or writes tx counter 0..254
            if (!s_q.srm) begin
               s_d.mode      = ST_RECOVER;
               s_d.rcv_cnt   = 8'h00;
               s_d.idle_wait = 1'b1;
            end
         end
         ST_RECOVER: begin
            if (bus_free) begin
               if (s_q.rcv_cnt == RECOVER_LAST) begin
                  s_d.mode      = ST_ACTIVE;
                  s_d.bus_off   = 1'b0;
                  s_d.err_flag  = 1'b0;
                  s_d.tec       = 8'h00;
                  s_d.rec       = 8'h00;
                  s_d.idle_wait = 1'b0;
               end else begin
                  s_d.rcv_cnt = s_q.rcv_cnt + 8'h01;
                  if (s_q.tec != 8'h00) begin
                     s_d.tec = s_q.tec - 8'h01;
                  end
               end
            end
         end
         ST_WAIT_ONE: begin
            if (!s_q.srm && bus_free) begin
               s_d.mode      = ST_ACTIVE;
               s_d.idle_wait = 1'b0;
            end
         end
         default: s_d.mode = ST_ACTIVE;
      endcase

      // warning flag follows counters outside recovery
      if (s_q.mode != ST_RECOVER) begin
         s_d.err_flag = (s_d.tec >= s_d.ewl) | (s_d.rec >= s_d.ewl);
      end
      s_d.warn_evt = (s_d.err_flag != s_q.err_flag)
                   | (s_d.bus_off != s_q.bus_off);
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q           <= '0;
         s_q.mode      <= ST_ACTIVE;
         s_q.ewl       <= EWL_RESET;
         s_q.tx_all_done_flag       <= 1'b1;
         s_q.idle_wait <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata          = s_q.prdata;
   assign pready          = s_q.pready;
   assign pslverr         = s_q.pslverr;
   assign soft_reset_mode = s_q.srm;
   assign bus_off         = s_q.bus_off;
   assign err_warn_event  = s_q.warn_evt;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_warn_flag_cmp: assert property (
      (s_q.mode == ST_ACTIVE && $past(s_q.mode) == ST_ACTIVE)
      |-> s_q.err_flag == ((s_q.tec >= s_q.ewl) | (s_q.rec >= s_q.ewl)))
      else $error("error flag does not follow counters");

   chk_srm_status_bits: assert property (
      s_q.srm |-> (status_w[5] && status_w[4]))
      else $error("status activity bits low in soft reset");

   chk_busoff_entry: assert property (
      (s_q.mode == ST_ACTIVE && !s_q.srm && evt.tx_err
       && s_q.tec > 8'hF7)
      |=> (s_q.bus_off && s_q.srm && s_q.tec == TEC_BUSOFF
           && s_q.rec == 8'h00 && err_warn_event))
      else $error("bus-off entry wrong");

   chk_busoff_hold: assert property (
      (s_q.mode == ST_BUSOFF && s_q.srm
       && !(wr_acc && paddr == OFF_STATUS)) |=> s_q.mode == ST_BUSOFF)
      else $error("left bus-off while soft reset set");

   chk_recover_step: assert property (
      (s_q.mode == ST_RECOVER && bus_free && s_q.rcv_cnt != RECOVER_LAST)
      |=> s_q.rcv_cnt == $past(s_q.rcv_cnt) + 8'h01
          && s_q.tec == (($past(s_q.tec) == 8'h00) ? 8'h00
                         : $past(s_q.tec) - 8'h01))
      else $error("recovery step wrong");

   chk_recover_end: assert property (
      (s_q.mode == ST_RECOVER && bus_free && s_q.rcv_cnt == RECOVER_LAST)
      |=> (s_q.mode == ST_ACTIVE && !s_q.bus_off && !s_q.err_flag
           && s_q.tec == 8'h00 && s_q.rec == 8'h00))
      else $error("recovery end wrong");

   chk_tcs_drop: assert property (
      (!s_q.srm && |txq.req) |=> !s_q.tx_all_done_flag)
      else $error("transmission complete not cleared by request");

   chk_overrun_set: assert property (
      (!s_q.srm && rxi.msg_valid && s_q.rx_cnt == 2'h2)
      |=> s_q.overrun && s_q.rx_cnt != 2'h0)
      else $error("overrun not flagged on full buffer");

   chk_ro_low_byte: assert property (
      (wr_acc && paddr == OFF_STATUS && s_q.mode == ST_ACTIVE
       && !s_q.srm && !evt.tx_err && !txq.req[0])
      |=> s_q.bus_off == 1'b0 && s_q.srm == 1'b0)
      else $error("status low byte write took effect");

   chk_busfree_run: assert property (
      (s_q.mode == ST_ACTIVE && s_q.idle_wait && !s_q.srm
       && s_q.rb_cnt == BUS_FREE_LAST && evt.bit_tick && evt.bit_recessive
       && !evt.tx_err)
      |=> !s_q.idle_wait)
      else $error("idle not reached after eleven recessive bits");

   chk_tbs_queued: assert property (
      (!s_q.srm && |txq.req) |=> !status_w[2])
      else $error("buffer status high with a queued message");

   chk_tcs_stays_low: assert property (
      (!s_q.srm && !s_q.tx_all_done_flag && (s_q.tx_pend & ~txq.done) != '0)
      |=> !s_q.tx_all_done_flag)
      else $error("transmission complete set with a send outstanding");

   chk_overrun_keep: assert property (
      (!s_q.srm && s_q.overrun && !rxi.clr_overrun) |=> s_q.overrun)
      else $error("overrun flag lost without a clear");

   chk_rbs_last_release: assert property (
      (!s_q.srm && rxi.release_rx_buffer_cmd && !rxi.msg_valid
       && s_q.rx_cnt == 2'h1) |=> !status_w[0])
      else $error("receive buffer status held after last release");

   chk_rbs_next_msg: assert property (
      (!s_q.srm && rxi.release_rx_buffer_cmd && s_q.rx_cnt == 2'h2)
      |=> status_w[0])
      else $error("receive buffer status lost with a message left");

   chk_tec_err_step: assert property (
      (s_q.mode == ST_ACTIVE && !s_q.srm && evt.tx_err
       && s_q.tec < 8'hF8) |=> s_q.tec == $past(s_q.tec) + 8'h08)
      else $error("transmit error counter step wrong");

   chk_rec_passive_ok: assert property (
      (s_q.mode == ST_ACTIVE && !s_q.srm && evt.rx_ok && !evt.rx_err
       && !evt.rx_err8 && !evt.tx_err && s_q.rec > REC_PASSIVE)
      |=> s_q.rec == REC_PASSIVE)
      else $error("receive counter not pulled back on success");

   chk_cnt_locked: assert property (
      (wr_acc && paddr == OFF_STATUS && !s_q.srm && s_q.mode == ST_ACTIVE
       && !evt.tx_err && !evt.tx_ok)
      |=> s_q.tec == $past(s_q.tec))
      else $error("counter written outside soft reset");

   chk_early_bus_on: assert property (
      (s_q.mode == ST_BUSOFF && s_q.srm && wr_acc && paddr == OFF_STATUS
       && pwdata[31:24] != MAX_ERR)
      |=> (!s_q.bus_off && s_q.mode == ST_WAIT_ONE))
      else $error("counter write did not end bus-off");

   chk_wait_one_end: assert property (
      (s_q.mode == ST_WAIT_ONE && !s_q.srm && bus_free)
      |=> (s_q.mode == ST_ACTIVE && !s_q.idle_wait))
      else $error("single bus-free wait did not end");

endmodule // cgsbo_top

// [cgsbo_can_node.sv]
// can bus partner: bit ticks, error events, queue and receive pulses
`timescale 1ns/1ps
module cgsbo_can_node
   import cgsbo_pkg::*;
(
   input  wire logic pclk,
   output cgsbo_evt_t evt,
   output cgsbo_txq_t txq,
   output cgsbo_rx_t  rxi
);
   logic tx_lvl;
   logic rx_lvl;

   initial begin
      evt = '0;
      txq = '0;
      rxi = '0;
      tx_lvl = 1'b0;
      rx_lvl = 1'b0;
   end

   // busy levels persist across pulses
   task automatic set_busy(input logic t, input logic r);
      @(posedge pclk);
      tx_lvl = t;
      rx_lvl = r;
      evt.tx_busy <= t;
      evt.rx_busy <= r;
   endtask

   // one-cycle pulses, cleared on the next edge
   task automatic pulse(input cgsbo_evt_t e, input cgsbo_txq_t t,
                        input cgsbo_rx_t r);
      @(posedge pclk);
      evt <= e | {tx_lvl, rx_lvl, 7'b0};
      txq <= t;
      rxi <= r;
      @(posedge pclk);
      evt <= {tx_lvl, rx_lvl, 7'b0};
      txq <= '0;
      rxi <= '0;
   endtask

   // n runs of 11 recessive bits, then one dominant bit
   task automatic bus_free(input int n);
      for (int i = 0; i < n * 11; i++) begin
         @(posedge pclk);
         evt.bit_tick      <= 1'b1;
         evt.bit_recessive <= 1'b1;
      end
      @(posedge pclk);
      evt.bit_recessive <= 1'b0;
      @(posedge pclk);
      evt.bit_tick      <= 1'b0;
   endtask
endmodule // cgsbo_can_node

// [tb_cgsbo_top.sv]
// testbench: apb access and status checks of the can global status block
`timescale 1ns/1ps
module tb_cgsbo_top
   import cgsbo_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        soft_reset_mode;
   logic        bus_off;
   logic        warn_evt;
   cgsbo_evt_t  evt;
   cgsbo_txq_t  txq;
   cgsbo_rx_t   rxi;
   logic [31:0] rd;
   logic        err_seen;
   int          num_errors = 0;
   int          tests_run = 0;
   localparam cgsbo_evt_t E0 = '0;
   localparam cgsbo_txq_t T0 = '0;
   localparam cgsbo_rx_t  R0 = '0;

   always #50 pclk = ~pclk;

   cgsbo_top u_cgsbo_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
      .txq(txq), .rxi(rxi), .soft_reset_mode(soft_reset_mode),
      .bus_off(bus_off), .err_warn_event(warn_evt));
   cgsbo_can_node u_cgsbo_can_node (.pclk(pclk), .evt(evt), .txq(txq),
      .rxi(rxi));

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // setup, access held until pready, release after that edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] msk, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, rd & msk, exp);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #2_000_000;
      num_errors++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("status rst", OFF_STATUS, 32'hFFFFFFFF, 32'h3C);
      rd_chk("ewl rst", OFF_EWL, 32'hFF, 32'h60);
      u_cgsbo_can_node.bus_free(0);
      for (int i = 0; i < 10; i++) u_cgsbo_can_node.pulse(9'h060, T0, R0);
      rd_chk("idle 10", OFF_STATUS, 32'h30, 32'h30);
      u_cgsbo_can_node.bus_free(1);
      rd_chk("idle 11", OFF_STATUS, 32'hFF, 32'h0C);
      u_cgsbo_can_node.set_busy(1'b1, 1'b0);
      rd_chk("tx busy", OFF_STATUS, 32'h30, 32'h20);
      u_cgsbo_can_node.set_busy(1'b0, 1'b1);
      rd_chk("rx busy", OFF_STATUS, 32'h30, 32'h10);
      u_cgsbo_can_node.set_busy(1'b0, 1'b0);
      u_cgsbo_can_node.pulse(E0, 9'b101_000_000, R0);
      rd_chk("tx req", OFF_STATUS, 32'h0C, 32'h00);
      u_cgsbo_can_node.pulse(E0, 9'b000_001_000, R0);
      rd_chk("tx one", OFF_STATUS, 32'h0C, 32'h00);
      u_cgsbo_can_node.pulse(E0, 9'b000_100_000, R0);
      rd_chk("tx all", OFF_STATUS, 32'h0C, 32'h0C);
      u_cgsbo_can_node.pulse(E0, T0, 3'b100);
      u_cgsbo_can_node.pulse(E0, T0, 3'b100);
      rd_chk("rx two", OFF_STATUS, 32'h03, 32'h01);
      u_cgsbo_can_node.pulse(E0, T0, 3'b100);
      rd_chk("rx over", OFF_STATUS, 32'h03, 32'h03);
      u_cgsbo_can_node.pulse(E0, T0, 3'b010);
      rd_chk("rel one", OFF_STATUS, 32'h01, 32'h01);
      u_cgsbo_can_node.pulse(E0, T0, 3'b010);
      rd_chk("rel two", OFF_STATUS, 32'h03, 32'h02);
      u_cgsbo_can_node.pulse(E0, T0, 3'b001);
      apb(1'b1, OFF_STATUS, 32'h000000FF);
      rd_chk("ro flags", OFF_STATUS, 32'hFFFFFFFF, 32'h0C);
      apb(1'b0, 8'h0C, 32'h0);
      check("unmapped", {31'h0, err_seen}, 32'h1);
      apb(1'b1, OFF_EWL, 32'h2);
      rd_chk("ewl wr", OFF_EWL, 32'hFF, 32'h02);
      u_cgsbo_can_node.pulse(9'h002, T0, R0);
      rd_chk("below", OFF_STATUS, 32'h00FF0040, 32'h00010000);
      u_cgsbo_can_node.pulse(9'h002, T0, R0);
      rd_chk("warn", OFF_STATUS, 32'h00FF0040, 32'h00020040);
      for (int i = 0; i < 32; i++) u_cgsbo_can_node.pulse(9'h008, T0, R0);
      @(negedge pclk);
      check("busoff pin", {30'h0, bus_off, soft_reset_mode}, 32'h3);
      check("warn pin", {31'h0, warn_evt}, 32'h1);
      rd_chk("busoff", OFF_STATUS, 32'hFFFF00F0, 32'h7F0000F0);
      repeat (30) @(posedge pclk);
      check("hold", {31'h0, bus_off}, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h0);
      u_cgsbo_can_node.bus_free(1);
      rd_chk("count", OFF_STATUS, 32'hFF000080, 32'h7E000080);
      u_cgsbo_can_node.bus_free(125);
      rd_chk("live", OFF_STATUS, 32'hFF000080, 32'h01000080);
      u_cgsbo_can_node.bus_free(2);
      rd_chk("recover", OFF_STATUS, 32'hFFFF00C0, 32'h0);
      check("bus on", {31'h0, bus_off}, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_STATUS, 32'h05120000);
      rd_chk("cnt wr", OFF_STATUS, 32'hFFFF0000, 32'h05120000);
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_STATUS, 32'h09000000);
      rd_chk("cnt lock", OFF_STATUS, 32'hFFFF0000, 32'h05120000);
      for (int i = 0; i < 32; i++) u_cgsbo_can_node.pulse(9'h008, T0, R0);
      apb(1'b1, OFF_STATUS, 32'h10000000);
      rd_chk("early off", OFF_STATUS, 32'hFF0000F0, 32'h10000070);
      apb(1'b1, OFF_CTRL, 32'h0);
      rd_chk("wait one", OFF_STATUS, 32'h30, 32'h30);
      u_cgsbo_can_node.bus_free(1);
      rd_chk("one free", OFF_STATUS, 32'h30, 32'h00);
      complete_run();
   end
endmodule // tb_cgsbo_top
